// ==== verilog/cmpo_channel.sv ====
/*
 * control, result and interrupt logic of one analog comparator channel,
 * with its APB register slave and the timer synchroniser.
 * assumes the analog core delivers an asynchronous compare level and
 * that pins and timer clocks are asynchronous to pclk.
 */
// Implementation choices: the address map and the APB register port.
// Notes on behaviour
// RULE_01 - invert bit complements the compare result
// RULE_02 - speed bit resets high, zero means low power
// RULE_03 - hysteresis bit switches input hysteresis
// RULE_04 - sync mode latches on timer falling edge
// RULE_05 - prescaled timer clock drives the latch
// RULE_06 - timer counts rising, latch moves falling
// RULE_07 - result can gate the timer
// RULE_08 - enabled rise or fall sets flag
// RULE_09 - software alone clears the flag
// RULE_10 - set beats a simultaneous clear
// RULE_11 - software enables all levels for interrupt
// RULE_12 - two-bit positive source select, four sources
// RULE_13 - two-bit negative pin select
// RULE_14 - inputs disconnected while comparator off
// RULE_15 - invert or on toggles can interrupt
// RULE_16 - result invalid until response time passes
// RULE_17 - results feed pwm auto-shutdown
// RULE_18 - analog pins read zero on port
// RULE_19 - on bit enables, off saves current
// RULE_20 - result registered every cycle
// RULE_21 - result in status and mirror
// RULE_22 - one-cycle edge pulses from previous result
// RULE_23 - positive select codes in source order
`timescale 1ns/1ps
`default_nettype none
`include "cmpo_regs.svh"

module cmpo_channel
   import cmpo_pkg::*;
#(
   parameter int PINS = 4,
   parameter int TW   = 16
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // analog core
   input  wire logic        compare_raw,
   output logic             comparator_on,
   output logic             input_connect,
   output logic             speed_power_select,
   output logic             hysteresis_enable,
   output cmpo_pos_sel_e    positive_input_select,
   output cmpo_neg_sel_t    negative_input_select,
   // pins and other channel
   input  wire logic [PINS-1:0] pin_in,
   input  wire logic        peer_result,
   output logic             result_pin_out,
   output logic             result_pin_oe_n,
   // timer and pwm
   input  wire logic        tmr_src_clk,
   input  wire logic        tmr_ps_clk,
   output logic             tmr_gate,
   output logic             pwm_shutdown_src,
   // interrupt
   output logic             int_req
);

   logic [7:0]      ctrl_a_r;
   logic [7:0]      ctrl_b_r;
   logic [2:0]      int_en_r;
   logic [1:0]      tmr_ctrl_r;
   logic [PINS-1:0] analog_select_r;
   logic            flag_r;
   logic            flag_nxt;
   logic [1:0]      raw_s_r;
   logic [1:0]      peer_s_r;
   logic [PINS-1:0] pin_s1_r;
   logic [PINS-1:0] pin_s2_r;
   logic            result_r;
   logic            prev_r;
   logic            rise_p;
   logic            fall_p;
   logic            final_result;
   logic            out_r;
   logic            gate_r;
   logic [31:0]     prdata_r;
   logic            wr_en;
   logic            rd_setup;
   logic            flag_clear;
   logic            result_nxt;

   cmpo_tsync_if #(.TW(TW)) ts ();

   cmpo_tsync #(.TW(TW)) u_tsync (
      .pclk        (pclk),
      .presetn     (presetn),
      .tmr_src_clk (tmr_src_clk),
      .tmr_ps_clk  (tmr_ps_clk),
      .t           (ts.tsync)
   );

   // address decode, used by write and by the error answer
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `CMPO_OFF_CTRL_A)   || (a == `CMPO_OFF_CTRL_B)   ||
               (a == `CMPO_OFF_INT_FLAG) || (a == `CMPO_OFF_INT_EN)   ||
               (a == `CMPO_OFF_MIRROR)   || (a == `CMPO_OFF_ANALOG_SELECT)    ||
               (a == `CMPO_OFF_PORT)     || (a == `CMPO_OFF_TMR_CTRL) ||
               (a == `CMPO_OFF_TMR_COUNT);
   endfunction

   // every access takes one wait-free access phase
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped(paddr);
   assign wr_en    = psel & penable & pwrite & mapped(paddr);
   assign rd_setup = psel & ~penable & ~pwrite;
   assign prdata   = prdata_r;

   // RULE_02 speed bit resets high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_a_r <= `CMPO_A_RESET;
      else if (wr_en && paddr == `CMPO_OFF_CTRL_A)
         ctrl_a_r <= pwdata[7:0] & 8'hb7;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_b_r <= `CMPO_B_RESET;
      else if (wr_en && paddr == `CMPO_OFF_CTRL_B)
         ctrl_b_r <= pwdata[7:0] & 8'hf3;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_en_r   <= 3'h0;
         tmr_ctrl_r <= 2'h0;
         analog_select_r    <= '1;
      end else if (wr_en && paddr == `CMPO_OFF_INT_EN) begin
         int_en_r   <= pwdata[2:0];
      end else if (wr_en && paddr == `CMPO_OFF_TMR_CTRL) begin
         tmr_ctrl_r <= pwdata[1:0];
      end else if (wr_en && paddr == `CMPO_OFF_ANALOG_SELECT) begin
         analog_select_r    <= pwdata[PINS-1:0];
      end
   end

   // two-flop synchronisers for asynchronous levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_s_r  <= 2'h0;
         peer_s_r <= 2'h0;
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         raw_s_r  <= {raw_s_r[0], compare_raw};
         peer_s_r <= {peer_s_r[0], peer_result};
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   // RULE_19 on bit powers the comparator
   assign comparator_on         = ctrl_a_r[`CMPO_A_ON];
   // RULE_14 inputs follow the on bit
   assign input_connect         = ctrl_a_r[`CMPO_A_ON];
   assign speed_power_select    = ctrl_a_r[`CMPO_A_SPEED];
   // RULE_03 hysteresis control
   assign hysteresis_enable     = ctrl_a_r[`CMPO_A_HYST];
   // RULE_12 RULE_23 positive source in listed order
   assign positive_input_select = cmpo_pos_sel_e'(ctrl_b_r[`CMPO_B_POS_LO +: 2]);
   // RULE_13 negative pin select
   assign negative_input_select = ctrl_b_r[`CMPO_B_NEG_LO +: 2];

   // RULE_01 RULE_15 an off comparator reads low before inversion,
   // so toggling on or invert still moves the result
   assign result_nxt = (ctrl_a_r[`CMPO_A_ON] & raw_s_r[1]) ^ ctrl_a_r[`CMPO_A_INV];

   // RULE_20 result registered each cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_r <= 1'b0;
         prev_r   <= 1'b0;
      end else begin
         result_r <= result_nxt;
         prev_r   <= result_r;
      end
   end

   // RULE_22 one-cycle edge pulses
   assign rise_p = result_r & ~prev_r;
   assign fall_p = ~result_r & prev_r;

   // software clears the flag by writing one to it
   assign flag_clear = wr_en && paddr == `CMPO_OFF_INT_FLAG && pwdata[0];

   // RULE_08 RULE_10 enabled edge sets, set beats clear
   always_comb begin
      flag_nxt = flag_r;
      if (flag_clear)
         flag_nxt = 1'b0;
      if ((rise_p && ctrl_b_r[`CMPO_B_RISE_EN]) || (fall_p && ctrl_b_r[`CMPO_B_FALL_EN]))
         flag_nxt = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) flag_r <= 1'b0;
      else          flag_r <= flag_nxt;
   end

   // RULE_11 all enable levels gate the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) int_req <= 1'b0;
      else          int_req <= flag_nxt & (&int_en_r);
   end

   // RULE_04 sync mode chooses the timer-latched copy
   assign ts.result       = result_r;
   assign ts.prescale_use = tmr_ctrl_r[`CMPO_T_PRESCALE];
   assign ts.gate_en      = tmr_ctrl_r[`CMPO_T_GATE];
   assign final_result    = ctrl_a_r[`CMPO_A_SYNC] ? ts.sync_result : result_r;

   // RULE_07 RULE_17 gate and shutdown outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r  <= 1'b0;
         gate_r <= 1'b0;
      end else begin
         out_r  <= final_result;
         gate_r <= final_result & tmr_ctrl_r[`CMPO_T_GATE];
      end
   end

   assign tmr_gate         = gate_r;
   assign pwm_shutdown_src = out_r;
   assign result_pin_out   = out_r;
   // pin driven only with output and comparator enabled
   assign result_pin_oe_n  = ~(ctrl_a_r[`CMPO_A_OE] & ctrl_a_r[`CMPO_A_ON]);

   // read data captured in the setup cycle; shown during the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_setup) begin
         if (paddr == `CMPO_OFF_CTRL_A)
            // RULE_21 status copy of result
            prdata_r <= {24'h0, ctrl_a_r[7], result_r, ctrl_a_r[5:0]};
         else if (paddr == `CMPO_OFF_CTRL_B)
            prdata_r <= {24'h0, ctrl_b_r};
         else if (paddr == `CMPO_OFF_INT_FLAG)
            prdata_r <= {31'h0, flag_r};
         else if (paddr == `CMPO_OFF_INT_EN)
            prdata_r <= {29'h0, int_en_r};
         else if (paddr == `CMPO_OFF_MIRROR)
            // RULE_21 shared mirror of both results
            prdata_r <= {30'h0, peer_s_r[1], result_r};
         else if (paddr == `CMPO_OFF_ANALOG_SELECT)
            prdata_r <= 32'(analog_select_r);
         else if (paddr == `CMPO_OFF_PORT)
            // RULE_18 analog pins read zero
            prdata_r <= 32'(pin_s2_r & ~analog_select_r);
         else if (paddr == `CMPO_OFF_TMR_CTRL)
            prdata_r <= {30'h0, tmr_ctrl_r};
         else if (paddr == `CMPO_OFF_TMR_COUNT)
            prdata_r <= 32'(ts.count);
         else
            prdata_r <= 32'h0000_0000;
      end
   end

   // checks

   // RULE_01 result follows invert and compare level
   pol_result_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
      ctrl_a_r[`CMPO_A_ON] && $stable(ctrl_a_r) ##1 $stable(ctrl_a_r)
      |-> result_r == ($past(raw_s_r[1]) ^ ctrl_a_r[`CMPO_A_INV]))
      else $error("result does not follow invert");

   // RULE_02 speed bit high out of reset
   speed_reset_a: assert property (@(posedge pclk) // RULE_02
      $rose(presetn) |-> speed_power_select)
      else $error("speed bit not high after reset");

   // RULE_03 hysteresis write reaches the output
   hyst_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
      wr_en && paddr == `CMPO_OFF_CTRL_A |=> hysteresis_enable == $past(pwdata[`CMPO_A_HYST]))
      else $error("hysteresis output missed write");

   // RULE_08 enabled rising or falling edge sets flag
   edge_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
      (rise_p && ctrl_b_r[`CMPO_B_RISE_EN]) || (fall_p && ctrl_b_r[`CMPO_B_FALL_EN]) |=> flag_r)
      else $error("enabled edge did not set flag");

   // RULE_10 set wins over clear
   set_wins_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
      flag_clear && rise_p && ctrl_b_r[`CMPO_B_RISE_EN] |=> flag_r ##1 (flag_r || $past(flag_clear)))
      else $error("clear beat a simultaneous set");

   // RULE_09 hardware never clears the flag
   flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
      flag_r && !flag_clear |=> flag_r)
      else $error("flag fell without software clear");

   // RULE_14 inputs off while comparator off
   inputs_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
      !comparator_on |-> !input_connect)
      else $error("inputs connected while off");

   // RULE_15 invert toggle while off moves result one cycle later
   off_toggle_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
      !comparator_on && $changed(ctrl_a_r[`CMPO_A_INV]) && !$changed(comparator_on)
      |=> result_r == ctrl_a_r[`CMPO_A_INV] || $changed(ctrl_a_r))
      else $error("off comparator ignored invert toggle");

   // RULE_22 edge pulse lasts one cycle
   rise_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
      rise_p |=> !rise_p)
      else $error("rising pulse longer than one cycle");

   // RULE_18 analog pins read zero in captured port data
   port_analog_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
      rd_setup && paddr == `CMPO_OFF_PORT |=> (prdata_r[PINS-1:0] & $past(analog_select_r)) == '0)
      else $error("analog pin read as one");

   // RULE_17 shutdown source follows result without sync
   shutdown_src_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
      !ctrl_a_r[`CMPO_A_SYNC] |=> pwm_shutdown_src == $past(result_r))
      else $error("shutdown source lost result");

   // RULE_22 falling pulse lasts one cycle
   fall_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
      fall_p |=> !fall_p)
      else $error("falling pulse longer than one cycle");

   // RULE_11 request needs every enable level
   int_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
      !(&int_en_r) |=> !int_req)
      else $error("request raised with an enable level clear");

endmodule

`default_nettype wire

// ==== verilog/cmpo_regs.svh ====
/*
 * register offsets, bit positions and reset values of the comparator channel.
 * assumes an APB slave with 32-bit data, one register per aligned word.
 */
`ifndef CMPO_REGS_SVH
`define CMPO_REGS_SVH

`define CMPO_OFF_CTRL_A    8'h00
`define CMPO_OFF_CTRL_B    8'h04
`define CMPO_OFF_INT_FLAG  8'h08
`define CMPO_OFF_INT_EN    8'h0c
`define CMPO_OFF_MIRROR    8'h10
`define CMPO_OFF_ANALOG_SELECT     8'h14
`define CMPO_OFF_PORT      8'h18
`define CMPO_OFF_TMR_CTRL  8'h1c
`define CMPO_OFF_TMR_COUNT 8'h20

// control a fields
`define CMPO_A_ON     7
`define CMPO_A_RESULT 6
`define CMPO_A_OE     5
`define CMPO_A_INV    4
`define CMPO_A_SPEED  2
`define CMPO_A_HYST   1
`define CMPO_A_SYNC   0
`define CMPO_A_RESET  8'h04

// control b fields
`define CMPO_B_RISE_EN 7
`define CMPO_B_FALL_EN 6
`define CMPO_B_POS_LO  4
`define CMPO_B_NEG_LO  0
`define CMPO_B_RESET   8'h00

// interrupt enable fields
`define CMPO_IE_COMPARE    0
`define CMPO_IE_PERIPHERAL 1
`define CMPO_IE_GLOBAL     2

// timer control fields
`define CMPO_T_PRESCALE 0
`define CMPO_T_GATE     1

`endif

// ==== verilog/cmpo_pkg.sv ====
/*
 * types shared by the comparator channel modules.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cmpo_pkg;

   // positive input source codes, in source order
   typedef enum logic [1:0] {
      CMPO_POS_PIN    = 2'h0,
      CMPO_POS_DAC    = 2'h1,
      CMPO_POS_FIXREF = 2'h2,
      CMPO_POS_GND    = 2'h3
   } cmpo_pos_sel_e;

   typedef logic [1:0] cmpo_neg_sel_t;

endpackage

// ==== verilog/cmpo_tsync_if.sv ====
/*
 * carrier between the comparator control and its timer synchroniser.
 * assumes both ends run on pclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface cmpo_tsync_if #(parameter int TW = 16);
   logic          result;
   logic          prescale_use;
   logic          gate_en;
   logic          sync_result;
   logic [TW-1:0] count;

   modport ctrl  (output result, output prescale_use, output gate_en,
                  input sync_result, input count);
   modport tsync (input result, input prescale_use, input gate_en,
                  output sync_result, output count);
endinterface

`default_nettype wire

// ==== verilog/cmpo_tsync.sv ====
/*
 * timer-side latch of the comparator result and the gated timer count.
 * assumes both timer clocks are slow against pclk and arrive from pins.
 */
`timescale 1ns/1ps
`default_nettype none

module cmpo_tsync
   import cmpo_pkg::*;
#(
   parameter int TW = 16
) (
   // system
   input  wire logic pclk,
   input  wire logic presetn,
   // timer clocks from outside
   input  wire logic tmr_src_clk,
   input  wire logic tmr_ps_clk,
   // control side
   cmpo_tsync_if.tsync t
);

   logic [1:0]    src_s_r;
   logic [1:0]    ps_s_r;
   logic          clk_prev_r;
   logic          sync_result_r;
   logic [TW-1:0] count_r;
   logic          tclk;
   logic          tfall;
   logic          trise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_s_r <= 2'h0;
         ps_s_r  <= 2'h0;
      end else begin
         src_s_r <= {src_s_r[0], tmr_src_clk};
         ps_s_r  <= {ps_s_r[0], tmr_ps_clk};
      end
   end

   // RULE_05 prescaled clock select
   assign tclk  = t.prescale_use ? ps_s_r[1] : src_s_r[1];
   assign tfall = clk_prev_r & ~tclk;
   assign trise = ~clk_prev_r & tclk;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) clk_prev_r <= 1'b0;
      else          clk_prev_r <= tclk;
   end

   // RULE_04 latch on falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)   sync_result_r <= 1'b0;
      else if (tfall) sync_result_r <= t.result;
   end

   // RULE_06 count on rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)                   count_r <= '0;
      else if (trise && !t.gate_en)   count_r <= count_r + 1'b1;
      else if (trise && t.gate_en && sync_result_r) count_r <= count_r + 1'b1;
   end

   assign t.sync_result = sync_result_r;
   assign t.count       = count_r;

   // RULE_04 latch only on falling edge
   sync_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
      !tfall |=> $stable(sync_result_r)) else $error("sync result moved without falling edge");
   // RULE_06 count moves only on rising edge
   count_edge_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
      !trise |=> $stable(count_r)) else $error("timer moved without rising edge");

endmodule

`default_nettype wire

// ==== sim/cmpo_analog_model.sv ====
/*
 * behavioural far side: analog source levels, compare level, timer clocks.
 * assumes the bench sets levels in low bytes and the clock run controls.
 */
`timescale 1ns/1ps
`default_nettype none

module cmpo_analog_model
   import cmpo_pkg::*;
(
   // from the channel
   input  wire logic          pclk,
   input  wire logic          input_connect,
   input  wire cmpo_pos_sel_e pos_sel,
   input  wire cmpo_neg_sel_t neg_sel,
   // from the bench
   input  wire logic [31:0]   pos_mv,
   input  wire logic [31:0]   neg_mv,
   input  wire logic          tmr_run,
   input  wire logic          ps_run,
   // to the channel
   output logic               compare_raw,
   output logic               tmr_src_clk,
   output logic               tmr_ps_clk
);
   logic       junk_r = 1'b0;
   logic [7:0] vp;
   logic [7:0] vn;

   assign vp = (pos_sel == CMPO_POS_GND) ? 8'h00 : pos_mv[{pos_sel, 3'h0} +: 8];
   assign vn = neg_mv[{neg_sel, 3'h0} +: 8];

   // disconnected inputs give no usable level, so it keeps changing
   always @(posedge pclk) junk_r <= ~junk_r;
   assign compare_raw = input_connect ? (vp > vn) : junk_r;

   initial begin
      tmr_src_clk = 1'b0;
      tmr_ps_clk  = 1'b0;
   end
   // clocks stand still while not running, phase unrelated to pclk
   always #43 if (tmr_run) tmr_src_clk = ~tmr_src_clk;
   always #171 if (ps_run) tmr_ps_clk = ~tmr_ps_clk;
endmodule

`default_nettype wire

// ==== sim/tb_comparator_output_logic.sv ====
/*
 * self-checking bench of the comparator channel over apb.
 * assumes the analog model in cmpo_analog_model and a 100 MHz pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cmpo_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_comparator_output_logic
   import cmpo_pkg::*;
;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0;
   logic          pready, pslverr, compare_raw, comparator_on, input_connect;
   logic [31:0]   prdata;
   logic          speed_power_select, hysteresis_enable;
   cmpo_pos_sel_e positive_input_select;
   cmpo_neg_sel_t negative_input_select;
   logic [3:0]    pin_in = 4'h0;
   logic          peer_result = 1'b0;
   logic          result_pin_out, result_pin_oe_n, tmr_src_clk, tmr_ps_clk;
   logic          tmr_gate, pwm_shutdown_src, int_req;
   logic [31:0]   pos_mv = 32'h0;
   logic [31:0]   neg_mv = 32'h0;
   logic          tmr_run = 1'b0;
   logic          ps_run = 1'b0;
   int            num_errors = 0;
   int            cmp_count = 0;
   logic [31:0]   rd, c0;
   logic          err, inv, er;
   logic [7:0]    vp, vn;

   always #5 pclk = ~pclk;

   cmpo_channel #(.PINS(4), .TW(16)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .compare_raw, .comparator_on, .input_connect, .speed_power_select,
      .hysteresis_enable, .positive_input_select, .negative_input_select, .pin_in, .peer_result,
      .result_pin_out, .result_pin_oe_n, .tmr_src_clk, .tmr_ps_clk, .tmr_gate, .pwm_shutdown_src,
      .int_req);

   cmpo_analog_model far (.pclk, .input_connect, .pos_sel(positive_input_select),
      .neg_sel(negative_input_select), .pos_mv, .neg_mv, .tmr_run, .ps_run, .compare_raw,
      .tmr_src_clk, .tmr_ps_clk);

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // entered just after a rising edge; leaves one idle edge behind unless chained
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit chain = 1'b0);
      int n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      penable <= 1'b0;
      // chained: the next setup follows this access at once
      if (!chain) begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask

   // level change on pin source and pin 0, then wait out the response time
   task automatic lv(input logic [7:0] p, input logic [7:0] q);
      pos_mv <= {24'h0, p};
      neg_mv <= {24'h0, q};
      idle(8);
   endtask

   function automatic logic exp_res(input logic [7:0] p, input logic [7:0] q, input logic i);
      return (p > q) ^ i;
   endfunction

   function automatic logic [31:0] exp_port(input logic [3:0] pins, input logic [3:0] an);
      return {28'h0, pins & ~an};
   endfunction

   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      void'($urandom(32'h77c8));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("ctrl_a", `CMPO_OFF_CTRL_A, 32'h4);
      `CHK("speed", 1'b1, speed_power_select)
      rchk("analog_select", `CMPO_OFF_ANALOG_SELECT, 32'hf);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `CMPO_OFF_CTRL_B, 32'(i * 16 + 3 - i));
         `CHK("pos_sel", i[1:0], positive_input_select)
         `CHK("neg_sel", 2'(3 - i), negative_input_select)
      end
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h2);
      `CHK("speed_low", 1'b0, speed_power_select)
      `CHK("hyst_on", 1'b1, hysteresis_enable)
      `CHK("connect_off", 1'b0, input_connect)
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h84);
      `CHK("hyst_off", 1'b0, hysteresis_enable)
      `CHK("on", 1'b1, comparator_on)
      `CHK("connect_on", 1'b1, input_connect)
      $display("test controls done");
      apb(1'b1, `CMPO_OFF_CTRL_B, 32'h0);
      for (int k = 0; k < 8; k++) begin
         vp = 8'($urandom);
         vn = 8'($urandom);
         if (vp == vn) vn = ~vp;
         inv = k[0];
         apb(1'b1, `CMPO_OFF_CTRL_A, 32'h84 | (32'(inv) << 4));
         peer_result <= 1'($urandom);
         lv(vp, vn);
         er = exp_res(vp, vn, inv);
         apb(1'b0, `CMPO_OFF_CTRL_A, 32'h0);
         `CHK("result", er, rd[6])
         apb(1'b0, `CMPO_OFF_MIRROR, 32'h0);
         `CHK("mirror", {peer_result, er}, rd[1:0])
         `CHK("shutdown", er, pwm_shutdown_src)
      end
      $display("test polarity done");
      // the polarity loop leaves invert set; edges below assume it clear
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h84);
      apb(1'b1, `CMPO_OFF_INT_EN, 32'h7);
      for (int j = 0; j < 4; j++) begin
         for (int e = 0; e < 2; e++) begin
            apb(1'b1, `CMPO_OFF_CTRL_B, 32'(j << 6));
            lv(e ? 8'd10 : 8'd200, 8'd100);
            apb(1'b1, `CMPO_OFF_INT_FLAG, 32'h1);
            rchk("flag_clr", `CMPO_OFF_INT_FLAG, 32'h0);
            lv(e ? 8'd200 : 8'd10, 8'd100);
            rchk("flag", `CMPO_OFF_INT_FLAG, {31'h0, e ? j[1] : j[0]});
            `CHK("int_req", e ? j[1] : j[0], int_req)
         end
      end
      apb(1'b1, `CMPO_OFF_INT_EN, 32'h3);
      idle(2);
      `CHK("int_masked", 1'b0, int_req)
      apb(1'b1, `CMPO_OFF_CTRL_B, 32'hc0);
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h4);
      idle(6);
      apb(1'b1, `CMPO_OFF_INT_FLAG, 32'h1);
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h14);
      idle(6);
      rchk("off_flag", `CMPO_OFF_INT_FLAG, 32'h1);
      rchk("off_result", `CMPO_OFF_CTRL_A, 32'h54);
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h4);
      idle(6);
      apb(1'b1, `CMPO_OFF_INT_FLAG, 32'h1);
      // rise lands two edges after the write, on the chained clear's access edge
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h14, 1'b1);
      apb(1'b1, `CMPO_OFF_INT_FLAG, 32'h1);
      rchk("set_wins", `CMPO_OFF_INT_FLAG, 32'h1);
      $display("test interrupt done");
      apb(1'b1, `CMPO_OFF_ANALOG_SELECT, 32'h5);
      pin_in <= 4'hf;
      idle(4);
      rchk("port", `CMPO_OFF_PORT, exp_port(4'hf, 4'h5));
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped_err", 1'b1, err)
      `CHK("unmapped_data", 32'h0, rd)
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'ha4);
      lv(8'd200, 8'd100);
      `CHK("oe_n", 1'b0, result_pin_oe_n)
      `CHK("pin_out", 1'b1, result_pin_out)
      $display("test pins done");
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h84);
      apb(1'b1, `CMPO_OFF_TMR_CTRL, 32'h2);
      tmr_run <= 1'b1;
      idle(20);
      `CHK("gate_on", 1'b1, tmr_gate)
      apb(1'b0, `CMPO_OFF_TMR_COUNT, 32'h0);
      c0 = rd;
      idle(40);
      apb(1'b0, `CMPO_OFF_TMR_COUNT, 32'h0);
      `CHK("count_run", 1'b1, rd > c0)
      lv(8'd10, 8'd100);
      idle(20);
      `CHK("gate_off", 1'b0, tmr_gate)
      apb(1'b0, `CMPO_OFF_TMR_COUNT, 32'h0);
      c0 = rd;
      idle(40);
      rchk("count_hold", `CMPO_OFF_TMR_COUNT, c0);
      tmr_run <= 1'b0;
      apb(1'b1, `CMPO_OFF_CTRL_A, 32'h85);
      lv(8'd200, 8'd100);
      idle(20);
      `CHK("sync_held", 1'b0, pwm_shutdown_src)
      tmr_run <= 1'b1;
      idle(40);
      `CHK("sync_moved", 1'b1, pwm_shutdown_src)
      apb(1'b1, `CMPO_OFF_TMR_CTRL, 32'h1);
      lv(8'd10, 8'd100);
      idle(40);
      `CHK("ps_held", 1'b1, pwm_shutdown_src)
      ps_run <= 1'b1;
      idle(90);
      `CHK("ps_moved", 1'b0, pwm_shutdown_src)
      $display("test timer done");
      report_and_stop();
   end
endmodule

`default_nettype wire
